// ===== shared/emsc_pkg.sv
// Constants and types for the external memory strobe and configuration block
// How it works
// - Lower-strobe select clear: second data strobe stays high all cycle.
// - Select set, lower block: second strobe is data strobe or output enable.
// - Select set, upper block: second strobe high, primary strobe unchanged.
// - Address strobe alternate bit enables driving the strobe through a port pin.
// - Toggle bit clear: bus pins move only on external accesses.
// - Toggle bit set, protection off: pins move on internal accesses, strobes stay high.
// - Drive strength bit picks small (0) or large (1) output buffers.
// - Save bit clear: entry pushes counter and flags, segment register replaces code segment.
// - Save bit set: entry pushes old code segment, loads interrupt segment, return restores old one.
// - Swap bit moves data page registers from page 21 into port data slots.
// - Lower address stretch adds 0..3 waits when address top bit is 0.
// - Upper address stretch adds 0..3 waits when address top bit is 1.
// - Writes to the second config register are ignored during a service routine.
// - Wait control register top bit always reads 0.
// - Clearing watchdog select bit puts the timer into watchdog mode.
// - Upper data stretch adds 0..7 internal clock waits on upper accesses.
// - Lower data stretch adds 0..7 waits to whichever strobe serves the lower block.
// - Data stretch counts internal clock cycles, which are core_clk cycles, not a divided clock.
// - Bus style 1: latch pulse, output enable strobe, write enable line.
// - Upper or lower block follows external address bit 21.
package emsc_pkg;
	localparam logic [5:0] PAGE_EXT_MEM    = 6'h15;
	localparam logic [5:0] PAGE_WAIT       = 6'h00;
	localparam logic [7:0] OFF_EXT_MEM_1   = 8'hF5;
	localparam logic [7:0] OFF_EXT_MEM_2   = 8'hF6;
	localparam logic [7:0] OFF_WAIT_CTRL   = 8'hFC;
	localparam logic [7:0] RST_EXT_MEM_1   = 8'h80;
	localparam logic [7:0] RST_EXT_MEM_2   = 8'h1F;
	localparam logic [7:0] RST_WAIT_CTRL   = 8'h7F;
	localparam logic [7:0] MASK_EXT_MEM_1  = 8'h76;
	localparam logic [7:0] MASK_EXT_MEM_2  = 8'h7F;
	localparam logic [7:0] MASK_WAIT_CTRL  = 8'h7F;
	localparam logic [7:0] REG_UNMAPPED    = 8'h00;
	// First config register fields
	localparam int BIT_BUS_STYLE     = 6;
	localparam int BIT_LOWER_SEL     = 5;
	localparam int BIT_AS_ALT        = 4;
	localparam int BIT_TOGGLE_INT    = 2;
	localparam int BIT_DRIVE_STR     = 1;
	// Second config register fields
	localparam int BIT_SEG_SAVE      = 6;
	localparam int BIT_PAGE_SWAP     = 5;
	localparam int BIT_MEM_SELECT    = 4;
	localparam int LSB_LOWER_ADDR_ST = 2;
	localparam int LSB_UPPER_ADDR_ST = 0;
	localparam int W_ADDR_ST         = 2;
	// Wait control register fields
	localparam int BIT_WDOG_SEL      = 6;
	localparam int LSB_UPPER_DATA_ST = 3;
	localparam int LSB_LOWER_DATA_ST = 0;
	localparam int W_DATA_ST         = 3;
	localparam int BIT_RSVD_TOP      = 7;

	typedef enum logic [1:0] {EMSC_IDLE, EMSC_T1, EMSC_T2} emsc_state_e;
endpackage

// ===== shared/emsc_ctr_if.sv
// Load and count signals between the cycle sequencer and its wait counter
`timescale 1ns/10ps
interface emsc_ctr_if #(parameter int W = 3) ();
	logic         load;
	logic [W-1:0] load_val;
	logic         dec;
	logic         zero;
	logic [W-1:0] count;
	modport owner (output load, output load_val, output dec, input zero, input count);
	modport ctr   (input load, input load_val, input dec, output zero, output count);
endinterface

// ===== core/emsc_wait_ctr.sv
// Loadable down counter that times strobe stretching
`timescale 1ns/10ps
module emsc_wait_ctr #(
	parameter int W = 3
) (
	input wire logic   core_clk, // Internal clock
	input wire logic   arst_n,   // Async reset, active low
	input wire logic   ce,       // Clock enable
	emsc_ctr_if.ctr    cif       // Load and status
);
	logic [W-1:0] cnt_ff;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= '0;
		end else if (ce) begin
			if (cif.load) begin
				cnt_ff <= cif.load_val;
			end else if (cif.dec && cnt_ff != '0) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end

	assign cif.zero  = (cnt_ff == '0);
	assign cif.count = cnt_ff;
endmodule

// ===== core/emsc_strobe_cfg.sv
// External memory bus strobe shaping with its configuration registers
`timescale 1ns/10ps
module emsc_strobe_cfg
	import emsc_pkg::*;
#(
	parameter int AW = 22,
	parameter int DW = 8
) (
	input  wire logic          core_clk,        // Internal clock
	input  wire logic          arst_n,          // Async reset, active low
	input  wire logic          ce,              // Clock enable, freezes all state
	input  wire logic [5:0]    reg_page,        // Register page
	input  wire logic [7:0]    reg_addr,        // Register offset in file
	input  wire logic          reg_wr,          // Register write strobe
	input  wire logic          reg_rd,          // Register read strobe
	input  wire logic [7:0]    reg_wdata,       // Register write data
	output logic      [7:0]    reg_rdata,       // Register read data
	input  wire logic          in_service,      // Service routine running
	input  wire logic          int_entry,       // Interrupt entry pulse
	input  wire logic          int_return,      // Interrupt return pulse
	input  wire logic [7:0]    int_seg,         // Interrupt segment register value
	input  wire logic [7:0]    popped_seg,      // Code segment popped from stack
	output logic               push_code_seg,   // Push code segment in frame
	output logic               code_seg_load,   // Load code segment
	output logic      [7:0]    code_seg_val,    // Value to load
	output logic               fetch_use_int_seg, // Fetch via interrupt segment
	input  wire logic          prot_disabled,   // Internal memory protection off
	input  wire logic          mem_req,         // Start memory cycle
	input  wire logic [AW-1:0] mem_addr,        // 22-bit memory address
	input  wire logic          mem_write,       // Cycle is a write
	input  wire logic          mem_internal,    // Cycle hits internal memory
	input  wire logic [DW-1:0] mem_wdata,       // Write data
	output logic               mem_busy,        // Cycle in progress
	output logic               mem_done,        // Cycle finished pulse
	output logic      [DW-1:0] mem_rdata,       // Captured read data
	output logic               as_n,            // Address strobe or latch pulse
	output logic               ds_n,            // Primary data strobe
	output logic               ds2_n,           // Second data strobe
	output logic               rw_n,            // Read/write or write enable
	output logic      [7:0]    ad_o,            // Multiplexed address/data out
	output logic               ad_oe,           // Address/data drive enable
	input  wire logic [7:0]    ad_i,            // Address/data pins in
	output logic      [7:0]    addr_hi_o,       // Address bits 15..8
	output logic               as_port_en,      // Address strobe on port pin
	output logic               drive_strength_sel, // Large output buffers
	output logic               page_reg_swap,   // Data page registers swapped
	output logic               memory_select_keep, // Memory selection bit
	output logic               watchdog_select_n // Low selects watchdog mode
);
	logic [7:0]  ext_mem_ctrl_1_ff;
	logic [7:0]  ext_mem_ctrl_2_ff;
	logic [7:0]  wait_stretch_ctrl_ff;
	emsc_state_e state_ff;
	emsc_state_e nxt_state;
	logic [AW-1:0] cyc_addr_ff;
	logic [DW-1:0] cyc_wdata_ff;
	logic          cyc_wr_ff;
	logic          cyc_int_ff;
	logic          cyc_toggle_ff;
	logic          cyc_mc_ff;
	logic          cyc_sel_ff;
	logic [W_DATA_ST-1:0] cyc_data_st_ff;
	logic          seg_save_ff;
	logic          wr_ext_mem_ctrl_1;
	logic          wr_ext_mem_ctrl_2;
	logic          wr_wcr;
	logic          req_upper;
	logic [W_DATA_ST-1:0] req_addr_st;
	logic [W_DATA_ST-1:0] req_data_st;
	logic          cyc_upper;
	logic          drive;
	logic          ds_phase;
	logic          strobe_act;
	logic [W_DATA_ST-1:0] t_len_ff;
	logic          last_t2_ff;

	emsc_ctr_if #(.W(W_DATA_ST)) cif ();

	emsc_wait_ctr #(.W(W_DATA_ST)) u_ctr (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.ce       (ce),
		.cif      (cif)
	);

	function automatic logic reg_hit(input logic [5:0] pg, input logic [7:0] off,
		input logic [5:0] want_pg, input logic [7:0] want_off);
		reg_hit = (pg == want_pg) && (off == want_off);
	endfunction

	assign wr_ext_mem_ctrl_1 = reg_wr && reg_hit(reg_page, reg_addr, PAGE_EXT_MEM, OFF_EXT_MEM_1);
	assign wr_ext_mem_ctrl_2 = reg_wr && reg_hit(reg_page, reg_addr, PAGE_EXT_MEM, OFF_EXT_MEM_2);
	assign wr_wcr  = reg_wr && reg_hit(reg_page, reg_addr, PAGE_WAIT, OFF_WAIT_CTRL);

	// Reserved bits keep their reset level; masks keep them out of writes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_mem_ctrl_1_ff <= RST_EXT_MEM_1;
		end else if (ce && wr_ext_mem_ctrl_1) begin
			ext_mem_ctrl_1_ff <= (ext_mem_ctrl_1_ff & ~MASK_EXT_MEM_1)
				| (reg_wdata & MASK_EXT_MEM_1);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_mem_ctrl_2_ff <= RST_EXT_MEM_2;
		end else if (ce && wr_ext_mem_ctrl_2 && !in_service) begin
			ext_mem_ctrl_2_ff <= (ext_mem_ctrl_2_ff & ~MASK_EXT_MEM_2)
				| (reg_wdata & MASK_EXT_MEM_2);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_stretch_ctrl_ff <= RST_WAIT_CTRL;
		end else if (ce && wr_wcr) begin
			wait_stretch_ctrl_ff <= wait_stretch_ctrl_ff & ~MASK_WAIT_CTRL
				| (reg_wdata & MASK_WAIT_CTRL);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= REG_UNMAPPED;
		end else if (ce && reg_rd) begin
			if (reg_hit(reg_page, reg_addr, PAGE_EXT_MEM, OFF_EXT_MEM_1)) begin
				reg_rdata <= ext_mem_ctrl_1_ff;
			end else if (reg_hit(reg_page, reg_addr, PAGE_EXT_MEM, OFF_EXT_MEM_2)) begin
				reg_rdata <= ext_mem_ctrl_2_ff;
			end else if (reg_hit(reg_page, reg_addr, PAGE_WAIT, OFF_WAIT_CTRL)) begin
				reg_rdata <= wait_stretch_ctrl_ff;
			end else begin
				reg_rdata <= REG_UNMAPPED;
			end
		end
	end

	// Straight field taps of the register flops
	assign as_port_en         = ext_mem_ctrl_1_ff[BIT_AS_ALT];
	assign drive_strength_sel = ext_mem_ctrl_1_ff[BIT_DRIVE_STR];
	assign page_reg_swap      = ext_mem_ctrl_2_ff[BIT_PAGE_SWAP];
	assign memory_select_keep = ext_mem_ctrl_2_ff[BIT_MEM_SELECT];
	assign watchdog_select_n  = wait_stretch_ctrl_ff[BIT_WDOG_SEL];

	// Block choice from address top bit, which is the external A21
	assign req_upper = mem_addr[AW-1];
	assign cyc_upper = cyc_addr_ff[AW-1];

	always_comb begin
		req_addr_st = '0;
		if (req_upper) begin
			req_addr_st[W_ADDR_ST-1:0] =
				ext_mem_ctrl_2_ff[LSB_UPPER_ADDR_ST +: W_ADDR_ST];
			req_data_st = wait_stretch_ctrl_ff[LSB_UPPER_DATA_ST +: W_DATA_ST];
		end else begin
			req_addr_st[W_ADDR_ST-1:0] =
				ext_mem_ctrl_2_ff[LSB_LOWER_ADDR_ST +: W_ADDR_ST];
			req_data_st = wait_stretch_ctrl_ff[LSB_LOWER_DATA_ST +: W_DATA_ST];
		end
	end

	// Settings are sampled once per cycle so a running cycle stays coherent
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_addr_ff    <= '0;
			cyc_wdata_ff   <= '0;
			cyc_wr_ff      <= 1'b0;
			cyc_int_ff     <= 1'b0;
			cyc_toggle_ff  <= 1'b0;
			cyc_mc_ff      <= 1'b0;
			cyc_sel_ff     <= 1'b0;
			cyc_data_st_ff <= '0;
		end else if (ce && state_ff == EMSC_IDLE && mem_req) begin
			cyc_addr_ff    <= mem_addr;
			cyc_wdata_ff   <= mem_wdata;
			cyc_wr_ff      <= mem_write;
			cyc_int_ff     <= mem_internal;
			cyc_toggle_ff  <= !mem_internal
				|| (ext_mem_ctrl_1_ff[BIT_TOGGLE_INT] && prot_disabled);
			cyc_mc_ff      <= ext_mem_ctrl_1_ff[BIT_BUS_STYLE];
			cyc_sel_ff     <= ext_mem_ctrl_1_ff[BIT_LOWER_SEL];
			cyc_data_st_ff <= req_data_st;
		end
	end

	// Counter ticks on the internal clock, never a divided core clock
	assign cif.load = (state_ff == EMSC_IDLE && mem_req)
		|| (state_ff == EMSC_T1 && cif.zero);
	assign cif.load_val = (state_ff == EMSC_IDLE) ? req_addr_st : cyc_data_st_ff;
	assign cif.dec = (state_ff != EMSC_IDLE);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			EMSC_IDLE: begin
				if (mem_req) begin
					nxt_state = EMSC_T1;
				end
			end
			EMSC_T1: begin
				if (cif.zero) begin
					nxt_state = EMSC_T2;
				end
			end
			EMSC_T2: begin
				if (cif.zero) begin
					nxt_state = EMSC_IDLE;
				end
			end
			default: nxt_state = EMSC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= EMSC_IDLE;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_busy   <= 1'b0;
			mem_done   <= 1'b0;
			mem_rdata  <= '0;
			last_t2_ff <= 1'b0;
		end else if (ce) begin
			mem_busy   <= (nxt_state != EMSC_IDLE);
			// Pins lag the sequencer, so data is taken one edge late while the strobe
			// is still on; otherwise a zero-wait read would sample an idle bus
			last_t2_ff <= (state_ff == EMSC_T2 && cif.zero);
			mem_done   <= last_t2_ff;
			if (last_t2_ff && !cyc_wr_ff && !cyc_int_ff) begin
				mem_rdata <= ad_i[DW-1:0];
			end
		end
	end

	assign drive    = (state_ff != EMSC_IDLE) && cyc_toggle_ff;
	// Data strobes never pulse on internal accesses
	assign ds_phase = (state_ff == EMSC_T2) && !cyc_int_ff;
	// In bus style 1 the strobe is an output enable, quiet on writes
	assign strobe_act = ds_phase && !(cyc_mc_ff && cyc_wr_ff);

	// Pins lag the sequencer by one edge; all come straight from flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			as_n      <= 1'b1;
			ds_n      <= 1'b1;
			ds2_n     <= 1'b1;
			rw_n      <= 1'b1;
			ad_o      <= 8'h00;
			ad_oe     <= 1'b0;
			addr_hi_o <= 8'h00;
		end else if (ce) begin
			// Primary strobe serves all when select clear, else upper block only
			ds_n  <= !(strobe_act && (!cyc_sel_ff || cyc_upper));
			// Second strobe only for lower block with select set
			ds2_n <= !(strobe_act && cyc_sel_ff && !cyc_upper);
			if (drive) begin
				// Style 1 turns the address strobe into a high latch pulse
				as_n <= cyc_mc_ff ? (state_ff == EMSC_T1)
					: (state_ff != EMSC_T1);
				rw_n <= cyc_mc_ff ? !(state_ff == EMSC_T2 && cyc_wr_ff)
					: !cyc_wr_ff;
				ad_oe     <= (state_ff == EMSC_T1) || cyc_wr_ff;
				ad_o      <= (state_ff == EMSC_T1) ? cyc_addr_ff[7:0] : cyc_wdata_ff[7:0];
				addr_hi_o <= cyc_addr_ff[15:8];
			end else if (state_ff == EMSC_IDLE) begin
				as_n  <= !ext_mem_ctrl_1_ff[BIT_BUS_STYLE];
				rw_n  <= 1'b1;
				ad_oe <= 1'b0;
			end
		end
	end

	// The save mode is fixed at entry so the return matches the frame pushed
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			push_code_seg     <= 1'b0;
			code_seg_load     <= 1'b0;
			code_seg_val      <= 8'h00;
			fetch_use_int_seg <= 1'b0;
			seg_save_ff       <= 1'b0;
		end else if (ce) begin
			push_code_seg <= 1'b0;
			code_seg_load <= 1'b0;
			if (int_entry) begin
				seg_save_ff <= ext_mem_ctrl_2_ff[BIT_SEG_SAVE];
				if (ext_mem_ctrl_2_ff[BIT_SEG_SAVE]) begin
					push_code_seg     <= 1'b1;
					code_seg_load     <= 1'b1;
					code_seg_val      <= int_seg;
					fetch_use_int_seg <= 1'b0;
				end else begin
					fetch_use_int_seg <= 1'b1;
				end
			end else if (int_return) begin
				fetch_use_int_seg <= 1'b0;
				if (seg_save_ff) begin
					code_seg_load <= 1'b1;
					code_seg_val  <= popped_seg;
				end
			end
		end
	end

	// Length of the current strobe phase, read only by the checks below
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			t_len_ff <= '0;
		end else if (ce) begin
			if (state_ff == EMSC_IDLE || (state_ff == EMSC_T1 && cif.zero)) begin
				t_len_ff <= '0;
			end else if (!cif.zero) begin
				t_len_ff <= t_len_ff + 1'b1;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence seq_entry_save;
		ce && int_entry && ext_mem_ctrl_2_ff[BIT_SEG_SAVE];
	endsequence

	sequence seq_push_pulse;
		push_code_seg && code_seg_load && code_seg_val == $past(int_seg) ##1 !push_code_seg;
	endsequence

	a_ds2_forced_high: assert property (ce && !cyc_sel_ff |=> ds2_n)
		else $error("second strobe active with select clear");
	a_ds_lower_quiet: assert property (ce && cyc_sel_ff && !cyc_upper |=> ds_n)
		else $error("primary strobe active on lower block");
	a_ds2_upper_quiet: assert property (ce && cyc_sel_ff && cyc_upper |=> ds2_n)
		else $error("second strobe active on upper block");
	a_pins_quiet_int: assert property (ce && state_ff != EMSC_IDLE && !cyc_toggle_ff
		|=> $stable(as_n) && $stable(rw_n) && !ad_oe)
		else $error("bus pins moved on internal access");
	a_no_strobe_int: assert property (ce && cyc_int_ff |=> ds_n && ds2_n)
		else $error("data strobe on internal access");
	a_isr_write_block: assert property (ce && wr_ext_mem_ctrl_2 && in_service
		|=> $stable(ext_mem_ctrl_2_ff))
		else $error("second config register written in service routine");
	a_wcr_top_zero: assert property (ce && reg_rd
		&& reg_hit(reg_page, reg_addr, PAGE_WAIT, OFF_WAIT_CTRL) |=> !reg_rdata[BIT_RSVD_TOP])
		else $error("wait control top bit read as one");
	a_data_stretch: assert property (ce && state_ff == EMSC_T2 && cif.zero
		|-> t_len_ff == cyc_data_st_ff)
		else $error("data strobe phase length wrong");
	a_addr_stretch: assert property (ce && state_ff == EMSC_IDLE && mem_req
		##1 (ce && state_ff == EMSC_T1) |-> cif.count == $past(req_addr_st))
		else $error("address stretch not loaded");
	a_wen_high_read: assert property (ce && cyc_mc_ff && !cyc_wr_ff && drive |=> rw_n)
		else $error("write enable active on read");
	a_push_on_entry: assert property (seq_entry_save |=> seq_push_pulse)
		else $error("code segment not pushed on entry");
	a_cfg_held: assert property (ce && state_ff != EMSC_IDLE
		|=> $stable(cyc_sel_ff) && $stable(cyc_mc_ff))
		else $error("cycle settings changed mid cycle");
endmodule

// ===== dv/emsc_mem_model.sv
// Behavioural external memory on the multiplexed address/data bus
`timescale 1ns/10ps
module emsc_mem_model (
	input  wire logic       as_n,     // Address strobe or latch pulse
	input  wire logic       ds_n,     // Primary data strobe
	input  wire logic       ds2_n,    // Second data strobe
	input  wire logic       rw_n,     // Read/write or write enable
	input  wire logic [7:0] ad_o,     // Bus driven by the block
	input  wire logic       ad_oe,    // Block drives the bus
	input  wire logic       latch_hi, // Wired for the latch-pulse bus style
	output logic      [7:0] ad_i      // Bus driven by the memory
);
	logic [7:0] mem [256];
	logic [7:0] a;
	logic [7:0] last;
	logic       rd_on;
	logic       wr_on;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = i[7:0] ^ 8'hA5;
		end
		a = 8'h00;
		last = 8'h00;
	end
	// Transparent latches: an edge capture would race the address-to-data switch
	always @* begin
		if (latch_hi ? as_n : !as_n) a = ad_o;
	end
	assign rd_on = rw_n && !ad_oe && (!ds_n || !ds2_n);
	assign wr_on = ad_oe && !rw_n && (latch_hi || !ds_n || !ds2_n);
	always @* begin
		if (wr_on) mem[a] = ad_o;
	end
	always @(negedge rd_on) last = mem[a];
	// Released bus shows inverted data so a late capture cannot pass by luck
	assign ad_i = rd_on ? mem[a] : ~last;
endmodule

// ===== dv/tb_external_memory_strobe_config.sv
// Self-checking bench for the external memory strobe and configuration block
`timescale 1ns/10ps
module tb_external_memory_strobe_config;
	import emsc_pkg::*;
	logic core_clk = 0, arst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, in_service = 0;
	logic int_entry = 0, int_return = 0, prot_disabled = 0, mem_req = 0;
	logic mem_write = 0, mem_internal = 0;
	logic [5:0] reg_page = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, int_seg = 0, popped_seg = 0, mem_wdata = 0;
	logic [21:0] mem_addr = 0;
	logic [7:0] reg_rdata, code_seg_val, mem_rdata, ad_o, ad_i, addr_hi_o, sh [256];
	logic push_code_seg, code_seg_load, fetch_use_int_seg, mem_busy, mem_done;
	logic as_n, ds_n, ds2_n, rw_n, ad_oe, as_port_en, drive_strength_sel;
	logic page_reg_swap, memory_select_keep, watchdog_select_n, rd_seen = 0;
	logic [7:0] e1 = 8'h80, e2 = 8'h1F, wc = 8'h7F;
	logic [8:0] md;
	logic [31:0] seed = 32'h35C2DE35;
	logic [7:0] reg_q [$];
	logic [8:0] mq_d [$];
	int mq_c [$];
	int cyc = 0, errors = 0, samples_checked = 0;
	emsc_strobe_cfg u_dut (.core_clk, .arst_n, .ce, .reg_page, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .in_service, .int_entry, .int_return, .int_seg, .popped_seg,
		.push_code_seg, .code_seg_load, .code_seg_val, .fetch_use_int_seg, .prot_disabled,
		.mem_req, .mem_addr, .mem_write, .mem_internal, .mem_wdata, .mem_busy, .mem_done,
		.mem_rdata, .as_n, .ds_n, .ds2_n, .rw_n, .ad_o, .ad_oe, .ad_i, .addr_hi_o,
		.as_port_en, .drive_strength_sel, .page_reg_swap, .memory_select_keep,
		.watchdog_select_n);
	emsc_mem_model u_mem (.as_n, .ds_n, .ds2_n, .rw_n, .ad_o, .ad_oe, .latch_hi(e1[6]), .ad_i);
	always #20 core_clk = ~core_clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk1(input logic s, input logic e);
		chk({15'h0000, s}, {15'h0000, e});
	endtask
	task automatic conclude();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [5:0] p, input logic [7:0] o, input logic [7:0] d);
		@(posedge core_clk);
		#1 {reg_page, reg_addr, reg_wdata, reg_wr} = {p, o, d, 1'b1};
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
		if (o == OFF_EXT_MEM_1) e1 = (d & 8'h76) | 8'h80;
		if (o == OFF_EXT_MEM_2 && !in_service) e2 = d & 8'h7F;
		if (o == OFF_WAIT_CTRL) wc = d & 8'h7F;
	endtask
	task automatic rd(input logic [5:0] p, input logic [7:0] o, input logic [7:0] x);
		@(posedge core_clk);
		#1 {reg_page, reg_addr, reg_rd} = {p, o, 1'b1};
		reg_q.push_back(x);
		@(posedge core_clk);
		#1 reg_rd = 1'b0;
	endtask
	task automatic pulse_int(input logic ent);
		logic [31:0] r;
		r = xs();
		@(posedge core_clk);
		#1 {int_seg, popped_seg, int_entry, int_return} = {r[15:0], ent, !ent};
		@(posedge core_clk);
		#1 {int_entry, int_return} = 2'b00;
	endtask
	task automatic mem_op(input logic [21:0] a, input logic w, input logic in_m);
		logic up, lo_ds, lo_ds2, lo_rw, ch_as, p_as, oe_seen;
		logic [2:0] dst;
		logic [31:0] rv;
		int n, fin;
		up = a[21];
		rv = xs();
		dst = up ? wc[5:3] : wc[2:0];
		{lo_ds, lo_ds2, lo_rw, ch_as, oe_seen, p_as, n, fin} = 0;
		@(posedge core_clk);
		#1 {mem_addr, mem_write, mem_internal, mem_wdata, mem_req} = {a, w, in_m, rv[7:0], 1'b1};
		if (!in_m) begin
			mq_c.push_back(cyc + 4 + int'(up ? e2[1:0] : e2[3:2]) + int'(dst));
			mq_d.push_back({!w, w ? 8'h00 : sh[a[7:0]]});
			if (w) sh[a[7:0]] = mem_wdata;
		end
		do begin
			@(posedge core_clk);
			#1 mem_req = 1'b0;
			if (n == 0) begin
				p_as = as_n;
				chk1(mem_busy, 1'b1);
			end else begin
				{lo_ds, lo_ds2, lo_rw, ch_as, oe_seen} |=
					{!ds_n, !ds2_n, !rw_n, as_n !== p_as, ad_oe};
			end
			if (fin > 0 || mem_done === 1'b1) fin++;
			n++;
		end while (fin < 2 && n < 40);
		chk1(n < 40, 1'b1);
		chk1(mem_busy, 1'b0);
		if (in_m) begin
			chk1(lo_ds || lo_ds2, 1'b0);
			chk1(ch_as, e1[2] && prot_disabled);
			if (!e1[2]) chk1(oe_seen, 1'b0);
		end else begin
			chk1(lo_ds, (up || !e1[5]) && !(e1[6] && w));
			chk1(lo_ds2, e1[5] && !up && !(e1[6] && w));
			chk1(lo_rw, w);
			chk1(ch_as, 1'b1);
			chk({8'h00, addr_hi_o}, {8'h00, a[15:8]});
		end
	endtask
	// Results are matched in arrival order against the driver's notes
	always @(posedge core_clk) begin
		cyc++;
		if (rd_seen) chk({8'h00, reg_rdata}, {8'h00, reg_q.pop_front()});
		rd_seen <= reg_rd;
		if (mem_done === 1'b1 && mq_c.size() > 0) begin
			chk(16'(cyc - 1), 16'(mq_c.pop_front()));
			md = mq_d.pop_front();
			if (md[8]) chk({8'h00, mem_rdata}, {8'h00, md[7:0]});
		end
	end
	initial begin
		#2000000;
		errors++;
		conclude();
	end
	initial begin
		logic [31:0] r;
		for (int i = 0; i < 256; i++) sh[i] = i[7:0] ^ 8'hA5;
		repeat (10) @(posedge core_clk);
		#1 arst_n = 1'b1;
		chk({11'h000, memory_select_keep, watchdog_select_n, page_reg_swap, as_port_en,
			drive_strength_sel}, 16'h0018);
		rd(PAGE_EXT_MEM, OFF_EXT_MEM_1, 8'h80);
		rd(PAGE_EXT_MEM, OFF_EXT_MEM_2, 8'h1F);
		rd(PAGE_WAIT, OFF_WAIT_CTRL, 8'h7F);
		rd(PAGE_WAIT, OFF_EXT_MEM_2, 8'h00);
		wr(PAGE_WAIT, OFF_WAIT_CTRL, 8'h80);
		rd(PAGE_WAIT, OFF_WAIT_CTRL, 8'h00);
		chk1(watchdog_select_n, 1'b0);
		ce = 1'b0;
		wr(PAGE_WAIT, OFF_WAIT_CTRL, 8'h52);
		ce = 1'b1;
		wc = 8'h00;
		chk1(watchdog_select_n, 1'b0);
		rd(PAGE_WAIT, OFF_WAIT_CTRL, 8'h00);
		wr(PAGE_EXT_MEM, OFF_EXT_MEM_1, 8'hFF);
		rd(PAGE_EXT_MEM, OFF_EXT_MEM_1, 8'hF6);
		chk1(as_port_en && drive_strength_sel, 1'b1);
		wr(PAGE_EXT_MEM, OFF_EXT_MEM_1, 8'h00);
		chk1(as_port_en || drive_strength_sel, 1'b0);
		in_service = 1'b1;
		wr(PAGE_EXT_MEM, OFF_EXT_MEM_2, 8'h30);
		rd(PAGE_EXT_MEM, OFF_EXT_MEM_2, 8'h1F);
		in_service = 1'b0;
		wr(PAGE_EXT_MEM, OFF_EXT_MEM_2, 8'h30);
		chk1(page_reg_swap, 1'b1);
		pulse_int(1'b1);
		chk({13'h0000, push_code_seg, code_seg_load, fetch_use_int_seg}, 16'h0001);
		pulse_int(1'b0);
		chk({13'h0000, push_code_seg, code_seg_load, fetch_use_int_seg}, 16'h0000);
		wr(PAGE_EXT_MEM, OFF_EXT_MEM_2, 8'h50);
		pulse_int(1'b1);
		chk({6'h00, push_code_seg, code_seg_load, code_seg_val}, {8'h03, int_seg});
		pulse_int(1'b0);
		chk({7'h00, code_seg_load, code_seg_val}, {8'h01, popped_seg});
		for (int i = 0; i < 24; i++) begin
			r = xs();
			wr(PAGE_EXT_MEM, OFF_EXT_MEM_1, r[7:0]);
			wr(PAGE_EXT_MEM, OFF_EXT_MEM_2, {r[15:13], 1'b1, r[11:8]});
			wr(PAGE_WAIT, OFF_WAIT_CTRL, (i == 0) ? 8'h40 : {2'b01, r[21:16]});
			prot_disabled = r[22];
			mem_op({r[23], 5'h00, r[20:13], r[31:24]}, 1'b1, 1'b0);
			mem_op({r[23], 5'h00, r[20:13], r[31:24]}, 1'b0, 1'b0);
			mem_op({r[23], 5'h00, r[20:13], r[31:24]}, 1'b0, 1'b1);
		end
		repeat (4) @(posedge core_clk);
		conclude();
	end
endmodule
